//--- shared/spl_map.vh
// Register offsets, field positions, reset values and timing for sector guard
`ifndef SPL_MAP_VH
`define SPL_MAP_VH

// Register byte offsets
`define SPL_OFF_CMD        8'h00
`define SPL_OFF_STATUS     8'h04
`define SPL_OFF_PWD_LO     8'h08
`define SPL_OFF_PWD_HI     8'h0C
`define SPL_OFF_SECT_QUERY 8'h10
`define SPL_OFF_BLK_GUARD  8'h14
`define SPL_OFF_MODE       8'h18

// Command register fields
`define SPL_CMD_OP_LSB     0
`define SPL_CMD_OP_MSB     3
`define SPL_CMD_SECT_LSB   8
`define SPL_CMD_VAL_BIT    16
`define SPL_CMD_MODE_LSB   17
`define SPL_CMD_MODE_MSB   18

// Command codes
`define SPL_OP_PSB_PROG    4'h1
`define SPL_OP_PSB_ERASE   4'h2
`define SPL_OP_DSB_WRITE   4'h3
`define SPL_OP_LOCK_CLEAR  4'h4
`define SPL_OP_PWD_UNLOCK  4'h5
`define SPL_OP_MODE_PROG   4'h6
`define SPL_OP_PWD_PROG    4'h7
`define SPL_OP_SOFT_RESET  4'h8
`define SPL_OP_ARRAY_CHECK 4'h9
`define SPL_OP_CLEAR_ERR   4'hA

// Status register fields
`define SPL_ST_BUSY        0
`define SPL_ST_PERR        1
`define SPL_ST_LOCK        2
`define SPL_ST_MODE_LSB    3
`define SPL_ST_MODE_MSB    4
`define SPL_ST_GUARD       5

// Block guard register fields
`define SPL_BG_BITS_MSB    2
`define SPL_BG_BOTTOM      3
`define SPL_BG_SWLOCK      7

// Protection mode encodings, bits 2:1
`define SPL_MODE_DEFAULT   2'b11
`define SPL_MODE_PERSIST   2'b10
`define SPL_MODE_PASSWORD  2'b01
`define SPL_MODE_ILLEGAL   2'b00

// Reset values
`define SPL_RST_PWD        64'hFFFF_FFFF_FFFF_FFFF
`define SPL_RST_LOCK       1'b1

// Times in microseconds and clock rate in MHz
`define SPL_UNLOCK_DELAY_US 100
`define SPL_PAGE_PROG_US    200
`define SPL_SECT_ERASE_US   500000
`define SPL_CLK_MHZ         125

// AXI responses
`define SPL_RESP_OKAY      2'b00
`define SPL_RESP_SLVERR    2'b10

`endif

//--- verilog/spl_sector_protection.v
// Sector program/erase protection logic with an AXI4-Lite register slave
// What this block does
// - Guard pin low with block guard lock bit 7 set rejects block guard writes.
// - Sector is protected when block guard range or sector guard protects it.
// - Each sector has persistent and dynamic bit; either zero blocks changes.
// - Persistent bits cannot be programmed or erased while lock is zero.
// - Persistent mode sets lock to one on power-on or hardware reset.
// - Persistent mode: no command sets lock; it stays zero until reset.
// - Password mode clears lock to zero on hardware reset; power-on reset sets lock to one and mode to default.
// - In password mode, matching supplied 64-bit password against hidden one sets lock to one.
// - Mode bits 11 default, 10 persistent, 01 password; 00 programming fails.
// - Once a mode bit is programmed, mode and password programming blocked.
// - Unconfigured part starts in persistent mode with all sectors open.
// - Mode programming takes a page program time, busy flag shows it.
// - Persistent bits program singly to zero, erase together to one.
// - Persistent bit program or erase with lock zero fails, nothing changes.
// - Status stays readable during persistent bit work; erase takes long.
// - Query command returns the persistent bit of an addressed sector.
// - Dynamic write clears or sets bit; only matters when persistent is one.
// - Password mode sets lock only by successful password unlock.
// - Dynamic bits return unprotected on power, software or hardware reset.
// - Unprotected only if both bits one; dynamic always writable.
// - Software reset leaves the lock unchanged.
// - In password mode, password mismatch sets program error and sets busy for the unlock delay.
// - Unlock accepted at most once per 100 us; match skips the delay.
`timescale 1ns/10ps
`include "spl_map.vh"

module spl_sector_protection #(
	parameter integer NUM_SECT     = 256,
	parameter integer SECT_W       = 8,
	parameter integer UNLOCK_CYC   = `SPL_UNLOCK_DELAY_US * `SPL_CLK_MHZ,
	parameter integer PAGE_CYC     = `SPL_PAGE_PROG_US * `SPL_CLK_MHZ,
	parameter integer ERASE_CYC    = `SPL_SECT_ERASE_US * `SPL_CLK_MHZ
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        wrGuardN,
	input  wire        hwRstN,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         sectorGuarded
);

	// Block guard range: bits n of 1 to 7 protect 1/2^(7-n) of sectors at top or bottom, 0 protects none
	function blkHit;
		input [2:0]        bits;
		input              bottom;
		input [SECT_W-1:0] sect;
		reg   [SECT_W:0]   span;
		begin
			span = NUM_SECT[SECT_W:0] >> (3'd7 - bits);
			if (bits == 3'd0)
				blkHit = 1'b0;
			else if (bottom)
				blkHit = ({1'b0, sect} < span);
			else
				blkHit = ({1'b0, sect} >= NUM_SECT[SECT_W:0] - span);
		end
	endfunction

	// Synchronisers for the guard pin and hardware reset pin
	reg  [1:0]        guardSync_q;
	reg  [1:0]        hwRstSync_q;
	// Protection state
	reg  [NUM_SECT-1:0] psb_q;
	reg  [NUM_SECT-1:0] dsb_q;
	reg               lock_q;
	reg  [1:0]        mode_q;
	reg  [63:0]       hiddenPwd_q;
	reg  [63:0]       suppliedPwd_q;
	reg  [2:0]        blkBits_q;
	reg               blkBottom_q;
	reg               swLock_q;
	reg  [SECT_W-1:0] querySect_q;
	// Operation status
	reg               busy_q;
	reg               perr_q;
	reg  [31:0]       busyCnt_q;
	// AXI write holding
	reg               awHeld_q;
	reg  [7:0]        awAddr_q;
	reg               wHeld_q;
	reg  [31:0]       wData_q;
	reg  [3:0]        wStrb_q;

	wire              guardLevelN;
	wire              hwRstActive;
	wire              regGuard;
	wire              doWrite;
	wire [3:0]        cmdOp;
	wire [SECT_W-1:0] cmdSect;
	wire              cmdVal;
	wire [1:0]        cmdMode;
	wire              cmdTake;
	wire              pwdModeSel;
	wire              querySectGuard;
	wire              queryBlk;
	wire              cmdSectGuard;
	reg  [31:0]       rdMux;
	reg               rdHit;

	assign guardLevelN = guardSync_q[1];
	assign hwRstActive = ~hwRstSync_q[1];
	assign regGuard    = ~guardLevelN & swLock_q;
	assign pwdModeSel  = (mode_q == `SPL_MODE_PASSWORD);

	assign cmdOp   = wData_q[`SPL_CMD_OP_MSB:`SPL_CMD_OP_LSB];
	assign cmdSect = wData_q[`SPL_CMD_SECT_LSB +: SECT_W];
	assign cmdVal  = wData_q[`SPL_CMD_VAL_BIT];
	assign cmdMode = wData_q[`SPL_CMD_MODE_MSB:`SPL_CMD_MODE_LSB];

	// Combined protection: block range OR either sector bit zero
	assign queryBlk = blkHit(blkBits_q, blkBottom_q, querySect_q);
	assign querySectGuard = queryBlk | ~psb_q[querySect_q]
		| ~dsb_q[querySect_q];
	assign cmdSectGuard = blkHit(blkBits_q, blkBottom_q, cmdSect)
		| ~psb_q[cmdSect] | ~dsb_q[cmdSect];

	// Registered copy of the queried sector's protection for the pin
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			sectorGuarded <= 1'b0;
		else
			sectorGuarded <= querySectGuard;
	end

	// AXI handshakes: address and data taken in any order
	assign s_axi_awready = ~awHeld_q;
	assign s_axi_wready  = ~wHeld_q;
	assign doWrite = awHeld_q & wHeld_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign cmdTake = doWrite & (awAddr_q == `SPL_OFF_CMD) & wStrb_q[0]
		& ~busy_q;

	// Two-flop synchronisers for pin inputs
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			guardSync_q <= 2'b11;
			hwRstSync_q <= 2'b11;
		end else begin
			guardSync_q <= {guardSync_q[0], wrGuardN};
			hwRstSync_q <= {hwRstSync_q[0], hwRstN};
		end
	end

	// AXI write channel capture and response
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			awHeld_q     <= 1'b0;
			awAddr_q     <= 8'h00;
			wHeld_q      <= 1'b0;
			wData_q      <= 32'h0000_0000;
			wStrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SPL_RESP_OKAY;
		end else begin
			if (s_axi_awvalid & ~awHeld_q) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~wHeld_q) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				case (awAddr_q)
				`SPL_OFF_CMD, `SPL_OFF_PWD_LO, `SPL_OFF_PWD_HI,
				`SPL_OFF_SECT_QUERY, `SPL_OFF_BLK_GUARD,
				`SPL_OFF_STATUS, `SPL_OFF_MODE: begin
					s_axi_bresp <= `SPL_RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `SPL_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Plain registers written by software
	always @(posedge sys_clk or posedge rst) begin : swRegs
		integer i;
		if (rst) begin
			suppliedPwd_q <= 64'h0000_0000_0000_0000;
			blkBits_q     <= 3'b000;
			blkBottom_q   <= 1'b0;
			swLock_q      <= 1'b0;
			querySect_q   <= {SECT_W{1'b0}};
		end else if (doWrite) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (wStrb_q[i] && awAddr_q == `SPL_OFF_PWD_LO)
					suppliedPwd_q[8*i +: 8] <= wData_q[8*i +: 8];
				if (wStrb_q[i] && awAddr_q == `SPL_OFF_PWD_HI)
					suppliedPwd_q[32+8*i +: 8] <= wData_q[8*i +: 8];
			end
			if (awAddr_q == `SPL_OFF_SECT_QUERY && wStrb_q[0])
				querySect_q <= wData_q[SECT_W-1:0];
			if (awAddr_q == `SPL_OFF_BLK_GUARD && wStrb_q[0]
				&& !regGuard) begin
				blkBits_q   <= wData_q[`SPL_BG_BITS_MSB:0];
				blkBottom_q <= wData_q[`SPL_BG_BOTTOM];
				swLock_q    <= wData_q[`SPL_BG_SWLOCK];
			end
		end
	end

	// Command execution, protection bits, lock and busy timing
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			psb_q       <= {NUM_SECT{1'b1}};
			dsb_q       <= {NUM_SECT{1'b1}};
			lock_q      <= `SPL_RST_LOCK;
			mode_q      <= `SPL_MODE_DEFAULT;
			hiddenPwd_q <= `SPL_RST_PWD;
			busy_q      <= 1'b0;
			perr_q      <= 1'b0;
			busyCnt_q   <= 32'h0000_0000;
		end else if (hwRstActive) begin
			dsb_q     <= {NUM_SECT{1'b1}};
			lock_q    <= ~pwdModeSel;
			busy_q    <= 1'b0;
			perr_q    <= 1'b0;
			busyCnt_q <= 32'h0000_0000;
		end else begin
			// Busy countdown ends the running operation
			if (busy_q) begin
				if (busyCnt_q == 32'h0000_0000)
					busy_q <= 1'b0;
				else
					busyCnt_q <= busyCnt_q - 32'h0000_0001;
			end
			if (cmdTake) begin
				case (cmdOp)
				`SPL_OP_PSB_PROG: begin
					if (lock_q) begin
						psb_q[cmdSect] <= 1'b0;
						busy_q    <= 1'b1;
						busyCnt_q <= PAGE_CYC - 1;
					end else begin
						perr_q <= 1'b1;
					end
				end
				`SPL_OP_PSB_ERASE: begin
					if (lock_q) begin
						psb_q     <= {NUM_SECT{1'b1}};
						busy_q    <= 1'b1;
						busyCnt_q <= ERASE_CYC - 1;
					end else begin
						perr_q <= 1'b1;
					end
				end
				`SPL_OP_DSB_WRITE: begin
					dsb_q[cmdSect] <= cmdVal;
				end
				`SPL_OP_LOCK_CLEAR: begin
					lock_q <= 1'b0;
				end
				`SPL_OP_PWD_UNLOCK: begin
					if (!pwdModeSel) begin
						perr_q <= 1'b1;
					end else if (suppliedPwd_q == hiddenPwd_q) begin
						lock_q <= 1'b1;
					end else begin
						perr_q    <= 1'b1;
						busy_q    <= 1'b1;
						busyCnt_q <= UNLOCK_CYC - 1;
					end
				end
				`SPL_OP_MODE_PROG: begin
					if (mode_q != `SPL_MODE_DEFAULT
						|| cmdMode == `SPL_MODE_ILLEGAL) begin
						perr_q <= 1'b1;
					end else begin
						mode_q    <= mode_q & cmdMode;
						busy_q    <= 1'b1;
						busyCnt_q <= PAGE_CYC - 1;
					end
				end
				`SPL_OP_PWD_PROG: begin
					if (mode_q != `SPL_MODE_DEFAULT) begin
						perr_q <= 1'b1;
					end else begin
						hiddenPwd_q <= hiddenPwd_q & suppliedPwd_q;
						busy_q      <= 1'b1;
						busyCnt_q   <= PAGE_CYC - 1;
					end
				end
				`SPL_OP_SOFT_RESET: begin
					dsb_q <= {NUM_SECT{1'b1}};
				end
				`SPL_OP_ARRAY_CHECK: begin
					if (cmdSectGuard) begin
						perr_q <= 1'b1;
					end else begin
						busy_q    <= 1'b1;
						busyCnt_q <= PAGE_CYC - 1;
					end
				end
				`SPL_OP_CLEAR_ERR: begin
					perr_q <= 1'b0;
				end
				default: begin
					perr_q <= perr_q;
				end
				endcase
			end
		end
	end

	// Read decode; status and query reflect live protection state
	always @* begin
		rdMux = 32'h0000_0000;
		rdHit = 1'b1;
		case (s_axi_araddr)
		`SPL_OFF_CMD: begin
			rdMux = 32'h0000_0000;
		end
		`SPL_OFF_STATUS: begin
			rdMux[`SPL_ST_BUSY] = busy_q;
			rdMux[`SPL_ST_PERR] = perr_q;
			rdMux[`SPL_ST_LOCK] = lock_q;
			rdMux[`SPL_ST_MODE_MSB:`SPL_ST_MODE_LSB] = mode_q;
			rdMux[`SPL_ST_GUARD] = regGuard;
		end
		`SPL_OFF_PWD_LO: begin
			rdMux = suppliedPwd_q[31:0];
		end
		`SPL_OFF_PWD_HI: begin
			rdMux = suppliedPwd_q[63:32];
		end
		`SPL_OFF_SECT_QUERY: begin
			rdMux[0] = psb_q[querySect_q];
			rdMux[1] = dsb_q[querySect_q];
			rdMux[2] = querySectGuard;
			rdMux[3] = queryBlk;
			rdMux[8 +: SECT_W] = querySect_q;
		end
		`SPL_OFF_BLK_GUARD: begin
			rdMux[`SPL_BG_BITS_MSB:0] = blkBits_q;
			rdMux[`SPL_BG_BOTTOM]     = blkBottom_q;
			rdMux[`SPL_BG_SWLOCK]     = swLock_q;
		end
		`SPL_OFF_MODE: begin
			rdMux[2:1] = mode_q;
			rdMux[0]   = 1'b1;
		end
		default: begin
			rdHit = 1'b0;
		end
		endcase
	end

	// AXI read channel: answer one cycle after address taken
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `SPL_RESP_OKAY;
		end else if (s_axi_arvalid & ~s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdMux;
			s_axi_rresp  <= rdHit ? `SPL_RESP_OKAY : `SPL_RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // spl_sector_protection

//--- test/spl_checker_assertions.sv
// Bus handshake and guard output checker for the sector protection block
`timescale 1ns/10ps
module spl_checker_assertions (
	input wire        sys_clk,
	input wire        rst,
	input wire        hwRstN,
	input wire        s_axi_awready,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        sectorGuarded
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Reads are answered at once, so status stays readable while busy
	property p_rAns;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rAns: assert property (p_rAns) else $error("read not answered");
	property p_rHold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rHold: assert property (p_rHold) else $error("read data dropped");
	property p_rDone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rDone: assert property (p_rDone) else $error("read not retired");
	property p_arBlock;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arBlock: assert property (p_arBlock) else $error("second read taken");

	// Write answers follow both halves and stand until taken
	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("write answer dropped");
	property p_bDone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid [*2];
	endproperty
	a_bDone: assert property (p_bDone) else $error("write not retired");
	property p_bRise;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	a_bRise: assert property (p_bRise) else $error("early write answer");

	// Guard output moves one cycle after a register write, or up to four cycles after hardware reset goes low
	property p_guard;
		!$stable(sectorGuarded) |-> $past(s_axi_bvalid)
			&& !$past(s_axi_bvalid, 2) || !($past(hwRstN, 1)
			&& $past(hwRstN, 2) && $past(hwRstN, 3) && $past(hwRstN, 4));
	endproperty
	a_guard: assert property (p_guard) else $error("guard moved alone");
endmodule // spl_checker_assertions

//--- test/spl_host_model.sv
// Host controller model: AXI4-Lite master issuing protection commands
`timescale 1ns/10ps
module spl_host_model (
	input  wire        sys_clk,
	output reg  [7:0]  s_axi_awaddr = 8'h00,
	output reg         s_axi_awvalid = 1'b0,
	input  wire        s_axi_awready,
	output reg  [31:0] s_axi_wdata = 32'h0000_0000,
	output reg  [3:0]  s_axi_wstrb = 4'hF,
	output reg         s_axi_wvalid = 1'b0,
	input  wire        s_axi_wready,
	input  wire [1:0]  s_axi_bresp,
	input  wire        s_axi_bvalid,
	output reg         s_axi_bready = 1'b0,
	output reg  [7:0]  s_axi_araddr = 8'h00,
	output reg         s_axi_arvalid = 1'b0,
	input  wire        s_axi_arready,
	input  wire [31:0] s_axi_rdata,
	input  wire [1:0]  s_axi_rresp,
	input  wire        s_axi_rvalid,
	output reg         s_axi_rready = 1'b0
);
	// Write one word; a response of 2'b11 marks a timeout
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		integer n;
		reg ta, tw, bv;
		begin
			r = 2'b11;
			bv = 1'b0;
			@(posedge sys_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 64 && !bv; n = n + 1) begin
				@(negedge sys_clk);
				ta = s_axi_awvalid & s_axi_awready;
				tw = s_axi_wvalid & s_axi_wready;
				bv = s_axi_bvalid;
				if (bv) r = s_axi_bresp;
				@(posedge sys_clk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (ta) s_axi_awaddr <= ~a; // Released lines do not keep value
				if (tw) s_axi_wvalid <= 1'b0;
				if (tw) s_axi_wdata <= ~d;
			end
			s_axi_bready <= 1'b0;
		end
	endtask

	// Read one word; a response of 2'b11 marks a timeout
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		integer n;
		reg ta, rv;
		begin
			r = 2'b11;
			rv = 1'b0;
			d = 32'h0000_0000;
			@(posedge sys_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 64 && !rv; n = n + 1) begin
				@(negedge sys_clk);
				ta = s_axi_arvalid & s_axi_arready;
				rv = s_axi_rvalid;
				if (rv) d = s_axi_rdata;
				if (rv) r = s_axi_rresp;
				@(posedge sys_clk);
				if (ta) s_axi_arvalid <= 1'b0;
				if (ta) s_axi_araddr <= ~a;
			end
			s_axi_rready <= 1'b0;
		end
	endtask
endmodule // spl_host_model

//--- test/spl_testbench.sv
// Self-checking bench for the sector protection block
`timescale 1ns/10ps
`include "spl_map.vh"
module testbench;
	localparam [7:0] CMD = `SPL_OFF_CMD, ST = `SPL_OFF_STATUS;
	localparam [7:0] LO = `SPL_OFF_PWD_LO, QRY = `SPL_OFF_SECT_QUERY;
	localparam [7:0] BG = `SPL_OFF_BLK_GUARD, MD = `SPL_OFF_MODE;
	localparam [1:0] OK = `SPL_RESP_OKAY, SLV = `SPL_RESP_SLVERR;
	reg         sys_clk, rst, wrGuardN, hwRstN;
	wire [7:0]  s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0]  s_axi_wstrb;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	wire        s_axi_rvalid, s_axi_rready, sectorGuarded;
	integer     errCount, totalChecks;

	// Design with shortened counts, and the host that drives it
	spl_sector_protection #(.NUM_SECT(16), .SECT_W(4), .UNLOCK_CYC(20),
		.PAGE_CYC(10), .ERASE_CYC(30)) uut (.sys_clk, .rst, .wrGuardN,
		.hwRstN, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sectorGuarded);
	spl_host_model hm (.sys_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	// 125 MHz clock
	always #4 sys_clk = ~sys_clk;

	// Compare one value and count it
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			totalChecks = totalChecks + 1;
			if (g !== e) begin
				errCount = errCount + 1;
				$display("[ERR] %0s exp %h got %h", nm, e, g);
			end
		end
	endtask

	// Bus write and read with response check; timeouts end the run
	task w(input [7:0] a, input [31:0] d, input [1:0] er);
		reg [1:0] r;
		begin
			hm.wr(a, d, r);
			chk($sformatf("bresp %h", a), {30'd0, er}, {30'd0, r});
			if (r === 2'b11) summarize;
		end
	endtask
	task rc(input [7:0] a, input [31:0] e, input [1:0] er);
		reg [31:0] d;
		reg [1:0]  r;
		begin
			hm.rd(a, d, r);
			chk($sformatf("rresp %h", a), {30'd0, er}, {30'd0, r});
			if (r === 2'b11) summarize;
			chk($sformatf("reg %h", a), e, d);
		end
	endtask

	// Command word: op, sector, dynamic value, mode bits
	function [31:0] cm(input [3:0] op, input [7:0] s, input v, input [1:0] m);
		cm = {13'h0000, m, v, s, 4'h0, op};
	endfunction

	// Poll status until busy drops
	task idle;
		integer n;
		reg [31:0] d;
		reg [1:0]  r;
		begin
			d = 32'h0000_0001;
			for (n = 0; n < 40 && d[0] !== 1'b0; n = n + 1) hm.rd(ST, d, r);
			if (d[0] !== 1'b0) errCount = errCount + 1;
			if (d[0] !== 1'b0) summarize;
		end
	endtask

	// Hardware reset pulse through the synchroniser
	task hwr;
		begin
			hwRstN <= 1'b0;
			repeat (4) @(posedge sys_clk);
			hwRstN <= 1'b1;
			repeat (4) @(posedge sys_clk);
		end
	endtask

	// Counts and verdict
	task summarize;
		begin
			$display("Checks %0d, errors %0d", totalChecks, errCount);
			if (errCount == 0 && totalChecks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// Main sequence
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		wrGuardN = 1'b1;
		hwRstN = 1'b1;
		errCount = 0;
		totalChecks = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rc(ST, 32'h0000_001C, OK);
		w(QRY, 32'h0000_0005, OK);
		rc(QRY, 32'h0000_0503, OK);
		rc(8'h40, 32'h0000_0000, SLV);
		w(8'h40, 32'h0000_0001, SLV);
		w(CMD, cm(4'h3, 8'h05, 1'b0, 2'b00), OK);
		rc(QRY, 32'h0000_0505, OK);
		chk("guard pin", 32'h0000_0001, {31'd0, sectorGuarded});
		w(CMD, cm(4'h9, 8'h05, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_001E, OK);
		w(CMD, cm(4'hA, 8'h00, 1'b0, 2'b00), OK);
		w(CMD, cm(4'h8, 8'h00, 1'b0, 2'b00), OK);
		rc(QRY, 32'h0000_0503, OK);
		rc(ST, 32'h0000_001C, OK);
		w(CMD, cm(4'h1, 8'h05, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_001D, OK);
		idle;
		rc(QRY, 32'h0000_0506, OK);
		w(CMD, cm(4'h2, 8'h00, 1'b0, 2'b00), OK);
		idle;
		rc(QRY, 32'h0000_0503, OK);
		w(BG, 32'h0000_0007, OK);
		rc(QRY, 32'h0000_050F, OK);
		w(BG, 32'h0000_0080, OK);
		wrGuardN <= 1'b0;
		repeat (3) @(posedge sys_clk);
		w(BG, 32'h0000_0087, OK);
		rc(BG, 32'h0000_0080, OK);
		rc(ST, 32'h0000_003C, OK);
		wrGuardN <= 1'b1;
		repeat (3) @(posedge sys_clk);
		w(BG, 32'h0000_0000, OK);
		w(CMD, cm(4'h4, 8'h00, 1'b0, 2'b00), OK);
		w(CMD, cm(4'h1, 8'h05, 1'b0, 2'b00), OK);
		rc(QRY, 32'h0000_0503, OK);
		rc(ST, 32'h0000_001A, OK);
		w(CMD, cm(4'hA, 8'h00, 1'b0, 2'b00), OK);
		w(CMD, cm(4'h5, 8'h00, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_001A, OK);
		w(CMD, cm(4'h8, 8'h00, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_001A, OK);
		w(CMD, cm(4'h3, 8'h05, 1'b0, 2'b00), OK);
		rc(QRY, 32'h0000_0505, OK);
		hwr;
		rc(ST, 32'h0000_001C, OK);
		rc(QRY, 32'h0000_0503, OK);
		w(LO, 32'h0000_5A5A, OK);
		w(`SPL_OFF_PWD_HI, 32'h0000_00C3, OK);
		w(CMD, cm(4'h7, 8'h00, 1'b0, 2'b00), OK);
		idle;
		w(CMD, cm(4'h6, 8'h00, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_001E, OK);
		w(CMD, cm(4'hA, 8'h00, 1'b0, 2'b00), OK);
		w(CMD, cm(4'h6, 8'h00, 1'b0, 2'b01), OK);
		rc(ST, 32'h0000_000D, OK);
		idle;
		rc(MD, 32'h0000_0003, OK);
		w(CMD, cm(4'h6, 8'h00, 1'b0, 2'b10), OK);
		rc(ST, 32'h0000_000E, OK);
		hwr;
		rc(ST, 32'h0000_0008, OK);
		w(LO, 32'h0000_5A5B, OK);
		w(CMD, cm(4'h5, 8'h00, 1'b0, 2'b00), OK);
		w(LO, 32'h0000_5A5A, OK);
		w(CMD, cm(4'h5, 8'h00, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_000B, OK);
		idle;
		rc(ST, 32'h0000_000A, OK);
		w(CMD, cm(4'hA, 8'h00, 1'b0, 2'b00), OK);
		w(CMD, cm(4'h5, 8'h00, 1'b0, 2'b00), OK);
		rc(ST, 32'h0000_000C, OK);
		summarize;
	end
endmodule // testbench

bind spl_sector_protection spl_checker_assertions u_chk (.sys_clk, .rst,
	.hwRstN, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .sectorGuarded);
